// ### src/ect_pkg.sv
/*
  Package for the event counter timer channel: register indices, control
  field positions, reset values and source/edge encodings.
  Assumes nothing of its surroundings; every file that uses it names it explicitly.
*/
package ect_pkg;

  // ----------------------------------------------------------------------
  // widths
  // ----------------------------------------------------------------------
  localparam int unsigned CNT_W  = 16;
  localparam int unsigned ADDR_W = 4;
  localparam int unsigned PRIO_W = 3;

  // ----------------------------------------------------------------------
  // register indices on the plain register port
  // ----------------------------------------------------------------------
  localparam logic [ADDR_W-1:0] REG_COUNT  = 4'h0;
  localparam logic [ADDR_W-1:0] REG_CTRL   = 4'h1;
  localparam logic [ADDR_W-1:0] REG_STATUS = 4'h2;
  localparam logic [ADDR_W-1:0] REG_PRIO   = 4'h3;
  localparam logic [ADDR_W-1:0] REG_RELOAD = 4'h4;

  // ----------------------------------------------------------------------
  // control register fields
  // ----------------------------------------------------------------------
  localparam int unsigned CTL_START    = 0;
  localparam int unsigned CTL_TWO_PH   = 1;
  localparam int unsigned CTL_SRC_LO   = 2;
  localparam int unsigned CTL_EDGE_LO  = 4;
  localparam int unsigned CTL_DOWN     = 6;
  localparam int unsigned CTL_DIR_EXT  = 7;
  localparam int unsigned CTL_FREE_RUN = 8;
  localparam int unsigned CTL_PULSE    = 9;
  localparam int unsigned CTL_MUL4     = 10;
  localparam int unsigned CTL_OUT_VAL  = 11;
  localparam int unsigned CTL_OUT_DRV  = 12;
  localparam int unsigned CTL_IN_VAL   = 13;
  localparam int unsigned CTL_IN_DRV   = 14;
  localparam int unsigned CTL_W        = 15;

  // ----------------------------------------------------------------------
  // status register fields
  // ----------------------------------------------------------------------
  localparam int unsigned STS_REQ     = 0;
  localparam int unsigned STS_OUT_LVL = 1;
  localparam int unsigned STS_IN_LVL  = 2;
  localparam int unsigned STS_UP      = 3;

  // ----------------------------------------------------------------------
  // encodings and reset values
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    ECT_SRC_PIN  = 2'h0,
    ECT_SRC_SFT  = 2'h1,
    ECT_SRC_COMP = 2'h2,
    ECT_SRC_NONE = 2'h3
  } ect_src_t;

  typedef enum logic [1:0] {
    ECT_EDGE_RISE = 2'h0,
    ECT_EDGE_FALL = 2'h1,
    ECT_EDGE_BOTH = 2'h2,
    ECT_EDGE_OFF  = 2'h3
  } ect_edge_t;

  localparam logic [CNT_W-1:0]  CNT_RST  = 16'h0000;
  localparam logic [CNT_W-1:0]  CNT_MAX  = 16'hFFFF;
  localparam logic [CNT_W-1:0]  CNT_ZERO = 16'h0000;
  localparam logic [CTL_W-1:0]  CTL_RST  = 15'h0000;
  localparam logic [PRIO_W-1:0] PRIO_RST = 3'h0;

endpackage

// ### src/ect_evt_if.sv
/*
  Interface carrying the synchronised pin levels and their edge pulses
  from the pin front end to the two-phase decoder.
  Assumes one clock; all members are produced on ref_clk.
*/
`timescale 1ns/100ps
`default_nettype none
interface ect_evt_if;
  logic in_lvl;
  logic in_rise;
  logic in_fall;
  logic out_lvl;
  logic out_rise;
  logic out_fall;

  modport prod (output in_lvl, in_rise, in_fall, out_lvl, out_rise, out_fall);
  modport cons (input  in_lvl, in_rise, in_fall, out_lvl, out_rise, out_fall);
endinterface
`default_nettype wire

// ### src/ect_pin_sync.sv
/*
  Two-flop synchroniser for one pin, followed by an edge detector.
  Assumes the pin is asynchronous to ref_clk.
*/
`timescale 1ns/100ps
`default_nettype none
module ect_pin_sync (
  input  wire logic ref_clk,
  input  wire logic rst_n,
  input  wire logic pin,
  output logic      lvl,
  output logic      rise,
  output logic      fall
);
  logic meta_q;
  logic sync_q;
  logic prev_q;

  // meta_q is read by sync_q only
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
      prev_q <= 1'b0;
    end else begin
      meta_q <= pin;
      sync_q <= meta_q;
      prev_q <= sync_q;
    end
  end

  assign lvl  = sync_q;
  assign rise = sync_q & ~prev_q;
  assign fall = ~sync_q & prev_q;
endmodule // ect_pin_sync
`default_nettype wire

// ### src/ect_quad.sv
/*
  Two-phase decoder: turns edges on the two phase pins into up and down
  count steps, either in normal or in multiply-by-4 processing.
  Assumes synchronised levels and one-cycle edge pulses on the interface.
*/
`timescale 1ns/100ps
`default_nettype none
module ect_quad (
  ect_evt_if.cons   evt,
  input  wire logic mul4,
  output logic      step_up,
  output logic      step_dn
);
  logic nrm_up;
  logic nrm_dn;
  logic m4_up;
  logic m4_dn;

  // normal: only edges of the first phase while the second is high
  assign nrm_up = evt.in_rise & evt.out_lvl;
  assign nrm_dn = evt.in_fall & evt.out_lvl;

  // x4: every edge; direction from which phase leads
  assign m4_up = (evt.in_rise & evt.out_lvl) | (evt.in_fall & ~evt.out_lvl) |
                 (evt.out_rise & ~evt.in_lvl) | (evt.out_fall & evt.in_lvl);
  assign m4_dn = (evt.in_rise & ~evt.out_lvl) | (evt.in_fall & evt.out_lvl) |
                 (evt.out_rise & evt.in_lvl) | (evt.out_fall & ~evt.in_lvl);

  // a glitch giving both at once is dropped rather than guessed
  assign step_up = mul4 ? (m4_up & ~m4_dn) : nrm_up;
  assign step_dn = mul4 ? (m4_dn & ~m4_up) : nrm_dn;
endmodule // ect_quad
`default_nettype wire

// ### src/ect_top.sv
/*
  Event counter timer channel: 16-bit counter with reload register,
  single-phase and two-phase counting, pulse output, interrupt request.
  Assumes a register master on ref_clk with one-cycle strobes and read
  data sampled in the cycle after the read strobe; pins are asynchronous.
*/
`timescale 1ns/100ps
`default_nettype none
module ect_top #(
  parameter int unsigned CNT_W  = ect_pkg::CNT_W,
  parameter int unsigned PRIO_W = ect_pkg::PRIO_W
) (
  input  wire logic                      ref_clk,
  input  wire logic                      rst_n,
  // register port
  input  wire logic [ect_pkg::ADDR_W-1:0] reg_addr,
  input  wire logic [CNT_W-1:0]          reg_wdata,
  input  wire logic                      reg_wr,
  input  wire logic                      reg_rd,
  output logic      [CNT_W-1:0]          reg_rdata,
  // neighbouring timers, same clock
  input  wire logic                      second_family_timer_two_ovf,
  input  wire logic                      companion_event_timer_ovf,
  // interrupt acceptance
  input  wire logic                      global_int_en,
  input  wire logic [PRIO_W-1:0]         processor_priority_level,
  output logic                           irq_request,
  output logic                           irq_accept,
  output logic                           wrap_pulse,
  // pins
  input  wire logic                      event_input_pin_i,
  output logic                           event_input_pin_o,
  output logic                           event_input_pin_oe_n,
  input  wire logic                      event_output_pin_i,
  output logic                           event_output_pin_o,
  output logic                           event_output_pin_oe_n
);

  // ----------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------
  logic [CNT_W-1:0]          cnt_q,    cnt_d;
  logic [CNT_W-1:0]          rld_q,    rld_d;
  logic [ect_pkg::CTL_W-1:0] ctl_q,    ctl_d;
  logic [PRIO_W-1:0]         prio_q,   prio_d;
  logic                      req_q,    req_d;
  logic                      acc_q,    acc_d;
  logic                      wrap_q,   wrap_d;
  logic                      up_q,     up_d;
  logic                      pout_q,   pout_d;
  logic [CNT_W-1:0]          rdata_q,  rdata_d;
  logic                      in_o_q,   in_o_d;
  logic                      in_oen_q, in_oen_d;
  logic                      out_o_q,  out_o_d;
  logic                      out_oen_q, out_oen_d;

  // ----------------------------------------------------------------------
  // control fields
  // ----------------------------------------------------------------------
  wire                  run      = ctl_q[ect_pkg::CTL_START];
  wire                  two_ph   = ctl_q[ect_pkg::CTL_TWO_PH];
  wire ect_pkg::ect_src_t  src   = ect_pkg::ect_src_t'(ctl_q[ect_pkg::CTL_SRC_LO +: 2]);
  wire ect_pkg::ect_edge_t edg   = ect_pkg::ect_edge_t'(ctl_q[ect_pkg::CTL_EDGE_LO +: 2]);
  wire                  sw_down  = ctl_q[ect_pkg::CTL_DOWN];
  wire                  dir_ext  = ctl_q[ect_pkg::CTL_DIR_EXT];
  wire                  free_run = ctl_q[ect_pkg::CTL_FREE_RUN];
  wire                  pulse_on = ctl_q[ect_pkg::CTL_PULSE];
  wire                  mul4     = ctl_q[ect_pkg::CTL_MUL4];

  // ----------------------------------------------------------------------
  // pin front end
  // ----------------------------------------------------------------------
  ect_evt_if evt ();

  ect_pin_sync u_in_sync (
    .ref_clk (ref_clk),
    .rst_n   (rst_n),
    .pin     (event_input_pin_i),
    .lvl     (evt.in_lvl),
    .rise    (evt.in_rise),
    .fall    (evt.in_fall)
  );

  ect_pin_sync u_out_sync (
    .ref_clk (ref_clk),
    .rst_n   (rst_n),
    .pin     (event_output_pin_i),
    .lvl     (evt.out_lvl),
    .rise    (evt.out_rise),
    .fall    (evt.out_fall)
  );

  // ----------------------------------------------------------------------
  // two-phase decoder
  // ----------------------------------------------------------------------
  wire qd_up;
  wire qd_dn;

  ect_quad u_quad (
    .evt     (evt),
    .mul4    (mul4),
    .step_up (qd_up),
    .step_dn (qd_dn)
  );

  // ----------------------------------------------------------------------
  // single-phase source and direction
  // ----------------------------------------------------------------------
  wire pin_evt = (edg == ect_pkg::ECT_EDGE_RISE) ? evt.in_rise :
                 (edg == ect_pkg::ECT_EDGE_FALL) ? evt.in_fall :
                 (edg == ect_pkg::ECT_EDGE_BOTH) ? (evt.in_rise | evt.in_fall) :
                 1'b0;

  wire sp_evt  = (src == ect_pkg::ECT_SRC_PIN)  ? pin_evt :
                 (src == ect_pkg::ECT_SRC_SFT)  ? second_family_timer_two_ovf :
                 (src == ect_pkg::ECT_SRC_COMP) ? companion_event_timer_ovf :
                 1'b0;

  // output pin high selects up count when it serves as direction input
  wire sp_up   = dir_ext ? evt.out_lvl : ~sw_down;

  wire step    = run & (two_ph ? (qd_up | qd_dn) : sp_evt);
  wire step_up = two_ph ? qd_up : sp_up;

  // ----------------------------------------------------------------------
  // counter arithmetic
  // ----------------------------------------------------------------------
  wire ovf  = step & step_up & (cnt_q == ect_pkg::CNT_MAX);
  wire unf  = step & ~step_up & (cnt_q == ect_pkg::CNT_ZERO);
  wire wrap = ovf | unf;

  wire [CNT_W-1:0] cnt_inc = cnt_q + {{(CNT_W-1){1'b0}}, 1'b1};
  wire [CNT_W-1:0] cnt_dec = cnt_q - {{(CNT_W-1){1'b0}}, 1'b1};

  // free-run lets +1/-1 wrap naturally; otherwise the reload value
  wire [CNT_W-1:0] cnt_step = (wrap & ~free_run) ? rld_q :
                              (step_up ? cnt_inc : cnt_dec);

  // ----------------------------------------------------------------------
  // register decode
  // ----------------------------------------------------------------------
  wire wr_cnt  = reg_wr & (reg_addr == ect_pkg::REG_COUNT);
  wire wr_ctl  = reg_wr & (reg_addr == ect_pkg::REG_CTRL);
  wire wr_sts  = reg_wr & (reg_addr == ect_pkg::REG_STATUS);
  wire wr_prio = reg_wr & (reg_addr == ect_pkg::REG_PRIO);
  wire req_clr = wr_sts & reg_wdata[ect_pkg::STS_REQ];

  wire [CNT_W-1:0] sts_word = CNT_W'({up_q, evt.in_lvl, evt.out_lvl, req_q});

  wire [CNT_W-1:0] rd_mux =
    (reg_addr == ect_pkg::REG_COUNT)  ? cnt_q :
    (reg_addr == ect_pkg::REG_CTRL)   ? CNT_W'(ctl_q) :
    (reg_addr == ect_pkg::REG_STATUS) ? sts_word :
    (reg_addr == ect_pkg::REG_PRIO)   ? CNT_W'(prio_q) :
    (reg_addr == ect_pkg::REG_RELOAD) ? rld_q :
    ect_pkg::CNT_ZERO;

  // ----------------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------------
  // a stopped write reaches the counter; a running one waits for a wrap with free-run off
  assign cnt_d   = (wr_cnt & ~run) ? reg_wdata :
                   step ? cnt_step : cnt_q;
  assign rld_d   = wr_cnt ? reg_wdata : rld_q;
  assign ctl_d   = wr_ctl ? reg_wdata[ect_pkg::CTL_W-1:0] : ctl_q;
  assign prio_d  = wr_prio ? reg_wdata[PRIO_W-1:0] : prio_q;
  // a wrap in the clearing cycle keeps the request set
  assign req_d   = wrap | (req_q & ~req_clr);
  assign acc_d   = global_int_en & req_d & (prio_q > processor_priority_level);
  assign wrap_d  = wrap;
  assign up_d    = step ? step_up : up_q;
  assign pout_d  = pout_q ^ (wrap & pulse_on);
  assign rdata_d = reg_rd ? rd_mux : ect_pkg::CNT_ZERO;

  // ----------------------------------------------------------------------
  // pin drivers
  // ----------------------------------------------------------------------
  // output pin is an input in two-phase mode or when it selects direction
  wire out_is_in = two_ph | dir_ext;
  assign out_o_d   = pulse_on ? pout_d : ctl_q[ect_pkg::CTL_OUT_VAL];
  assign out_oen_d = ~(~out_is_in & (pulse_on | ctl_q[ect_pkg::CTL_OUT_DRV]));
  // input pin may only be driven when it is not the count source
  wire in_is_src   = two_ph | (src == ect_pkg::ECT_SRC_PIN);
  assign in_o_d    = ctl_q[ect_pkg::CTL_IN_VAL];
  assign in_oen_d  = ~(~in_is_src & ctl_q[ect_pkg::CTL_IN_DRV]);

  // ----------------------------------------------------------------------
  // flip-flops
  // ----------------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q  <= ect_pkg::CNT_RST;
      rld_q  <= ect_pkg::CNT_RST;
      ctl_q  <= ect_pkg::CTL_RST;
      prio_q <= ect_pkg::PRIO_RST;
    end else begin
      cnt_q  <= cnt_d;
      rld_q  <= rld_d;
      ctl_q  <= ctl_d;
      prio_q <= prio_d;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      req_q   <= 1'b0;
      acc_q   <= 1'b0;
      wrap_q  <= 1'b0;
      up_q    <= 1'b1;
      pout_q  <= 1'b0;
      rdata_q <= ect_pkg::CNT_ZERO;
    end else begin
      req_q   <= req_d;
      acc_q   <= acc_d;
      wrap_q  <= wrap_d;
      up_q    <= up_d;
      pout_q  <= pout_d;
      rdata_q <= rdata_d;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      in_o_q    <= 1'b0;
      in_oen_q  <= 1'b1;
      out_o_q   <= 1'b0;
      out_oen_q <= 1'b1;
    end else begin
      in_o_q    <= in_o_d;
      in_oen_q  <= in_oen_d;
      out_o_q   <= out_o_d;
      out_oen_q <= out_oen_d;
    end
  end

  // ----------------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------------
  assign reg_rdata             = rdata_q;
  assign irq_request           = req_q;
  assign irq_accept            = acc_q;
  assign wrap_pulse            = wrap_q;
  assign event_input_pin_o     = in_o_q;
  assign event_input_pin_oe_n  = in_oen_q;
  assign event_output_pin_o    = out_o_q;
  assign event_output_pin_oe_n = out_oen_q;

endmodule // ect_top
`default_nettype wire

// ### dv/ect_top_asserts.sv
/*
  Port-level assertions for the event counter timer channel.
  Assumes binding into ect_top; one clock, reset asynchronous active low.
*/
`timescale 1ns/100ps
`default_nettype none
module ect_top_asserts #(
  parameter int unsigned CNT_W  = 16,
  parameter int unsigned PRIO_W = 3
) (
  input wire logic                       ref_clk,
  input wire logic                       rst_n,
  input wire logic [ect_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [CNT_W-1:0]           reg_wdata,
  input wire logic                       reg_wr,
  input wire logic                       reg_rd,
  input wire logic [CNT_W-1:0]           reg_rdata,
  input wire logic                       second_family_timer_two_ovf,
  input wire logic                       companion_event_timer_ovf,
  input wire logic                       global_int_en,
  input wire logic [PRIO_W-1:0]          processor_priority_level,
  input wire logic                       irq_request,
  input wire logic                       irq_accept,
  input wire logic                       wrap_pulse,
  input wire logic                       event_input_pin_i,
  input wire logic                       event_input_pin_o,
  input wire logic                       event_input_pin_oe_n,
  input wire logic                       event_output_pin_i,
  input wire logic                       event_output_pin_o,
  input wire logic                       event_output_pin_oe_n
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  // recent count causes; pin edges need a few cycles through the synchroniser
  logic [7:0] act_q;
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) act_q <= '0;
    else act_q <= {act_q[6:0], second_family_timer_two_ovf | companion_event_timer_ovf
                   | $changed(event_input_pin_i) | $changed(event_output_pin_i)};
  end

  a_wrap_sets_req: assert property (wrap_pulse |-> irq_request)
    else $error("wrap without request");
  a_req_from_wrap: assert property ($rose(irq_request) |-> wrap_pulse)
    else $error("request rose without wrap");
  a_req_clear_cause: assert property ($fell(irq_request) |-> $past(reg_wr)
    && $past(reg_addr) == ect_pkg::REG_STATUS && $past(reg_wdata[ect_pkg::STS_REQ]))
    else $error("request dropped without clear");
  a_wrap_has_event: assert property (wrap_pulse |-> (|act_q))
    else $error("wrap without count event");
  a_accept_needs_en: assert property (irq_accept |-> $past(global_int_en))
    else $error("accept while disabled");
  a_accept_needs_req: assert property (irq_accept |-> irq_request)
    else $error("accept without request");
  a_accept_top_level: assert property
    ($past(processor_priority_level) == {PRIO_W{1'b1}} |-> !irq_accept)
    else $error("accept at top level");
  a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == '0)
    else $error("read data outside read cycle");
  a_rd_unmapped: assert property
    ($past(reg_rd) && $past(reg_addr) > ect_pkg::REG_RELOAD |-> reg_rdata == '0)
    else $error("unmapped read not zero");

  c_wrap: cover property (wrap_pulse);
  c_accept: cover property (irq_accept);
  c_clear: cover property ($fell(irq_request));
endmodule // ect_top_asserts

bind ect_top ect_top_asserts #(.CNT_W(CNT_W), .PRIO_W(PRIO_W)) i_ect_top_asserts (
  .ref_clk(ref_clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .second_family_timer_two_ovf(second_family_timer_two_ovf),
  .companion_event_timer_ovf(companion_event_timer_ovf), .global_int_en(global_int_en),
  .processor_priority_level(processor_priority_level), .irq_request(irq_request),
  .irq_accept(irq_accept), .wrap_pulse(wrap_pulse), .event_input_pin_i(event_input_pin_i),
  .event_input_pin_o(event_input_pin_o), .event_input_pin_oe_n(event_input_pin_oe_n),
  .event_output_pin_i(event_output_pin_i), .event_output_pin_o(event_output_pin_o),
  .event_output_pin_oe_n(event_output_pin_oe_n));
`default_nettype wire

// ### dv/ect_pulse_src.sv
/*
  External pulse and quadrature source driving the two channel pins.
  Assumes the bench calls its tasks; the channel's own drive wins on a pin.
*/
`timescale 1ns/100ps
`default_nettype none
module ect_pulse_src (
  input  wire logic ref_clk,
  input  wire logic in_o,
  input  wire logic in_oe_n,
  input  wire logic out_o,
  input  wire logic out_oe_n,
  output logic      in_pin,
  output logic      out_pin
);
  logic a_q = 1'b0;
  logic b_q = 1'b0;

  assign in_pin  = in_oe_n ? a_q : in_o;
  assign out_pin = out_oe_n ? b_q : out_o;

  // gap sets how promptly the source moves on to its next edge
  task automatic set(input logic a, input logic b, input int gap);
    @(posedge ref_clk);
    a_q <= a;
    b_q <= b;
    repeat (gap) @(posedge ref_clk);
  endtask

  // one full cycle of two trains a quarter period apart
  task automatic quad(input int dir, input int gap);
    if (dir > 0) begin
      set(1'b0, 1'b1, gap);
      set(1'b1, 1'b1, gap);
      set(1'b1, 1'b0, gap);
    end else begin
      set(1'b1, 1'b0, gap);
      set(1'b1, 1'b1, gap);
      set(1'b0, 1'b1, gap);
    end
    set(1'b0, 1'b0, gap);
  endtask
endmodule // ect_pulse_src
`default_nettype wire

// ### dv/event_counter_timer_test.sv
/*
  Self-checking bench for the event counter timer channel.
  Assumes the pulse source model and the bound assertion checker.
*/
`timescale 1ns/100ps
`default_nettype none
module event_counter_timer_test;
  localparam logic [15:0] ST = 16'h0001 << ect_pkg::CTL_START;
  localparam logic [15:0] SFT = 16'h0001 << ect_pkg::CTL_SRC_LO;
  localparam logic [15:0] CMP = 16'h0002 << ect_pkg::CTL_SRC_LO;
  localparam logic [15:0] DN = 16'h0001 << ect_pkg::CTL_DOWN;
  localparam logic [15:0] FR = 16'h0001 << ect_pkg::CTL_FREE_RUN;
  localparam logic [15:0] PU = (16'h0001 << ect_pkg::CTL_PULSE) | (16'h0001 << ect_pkg::CTL_OUT_DRV);
  logic        ref_clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic        sft_ovf = 1'b0;
  logic        cmp_ovf = 1'b0;
  logic        gie = 1'b0;
  logic [2:0]  lvl = 3'h0;
  logic [3:0]  reg_addr = 4'h0;
  logic [15:0] reg_wdata = 16'h0000;
  logic [15:0] reg_rdata, n;
  logic        irq_request, irq_accept, in_pin, out_pin, in_o, in_oe_n, out_o, out_oe_n;
  logic [31:0] lf = 32'ha585_f3c6;
  logic [15:0] cfg [4] = '{ST | CMP | DN | PU, ST | SFT, ST | CMP | DN | FR, ST | SFT | FR};
  int          cnt, rld, fails, checks_done, qd[6] = '{1, 1, -1, -1, -1, -1}, lvt[4] = '{4, 5, 3, 7};
  bit          run, fr, tgl, irq;

  ect_top i_ect_top (.ref_clk(ref_clk), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .second_family_timer_two_ovf(sft_ovf), .companion_event_timer_ovf(cmp_ovf),
    .global_int_en(gie), .processor_priority_level(lvl), .irq_request(irq_request),
    .irq_accept(irq_accept), .wrap_pulse(), .event_input_pin_i(in_pin),
    .event_input_pin_o(in_o), .event_input_pin_oe_n(in_oe_n), .event_output_pin_i(out_pin),
    .event_output_pin_o(out_o), .event_output_pin_oe_n(out_oe_n));
  ect_pulse_src i_ect_pulse_src (.ref_clk(ref_clk), .in_o(in_o), .in_oe_n(in_oe_n),
    .out_o(out_o), .out_oe_n(out_oe_n), .in_pin(in_pin), .out_pin(out_pin));

  // ----------------------------------------------------------------
  // reference model and bus tasks
  // ----------------------------------------------------------------
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic step(input int d);
    if (!run) return;
    cnt += d;
    if (cnt > 'hFFFF || cnt < 0) begin
      irq = 1'b1;
      tgl = ~tgl;
      cnt = fr ? cnt & 'hFFFF : rld;
    end
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
    if (a == ect_pkg::REG_COUNT) begin
      rld = d;
      if (!run) cnt = d;
    end
    if (a == ect_pkg::REG_CTRL) begin
      run = d[ect_pkg::CTL_START];
      fr = d[ect_pkg::CTL_FREE_RUN];
    end
  endtask

  task automatic rc(input logic [3:0] a, input logic [15:0] exp, input string what);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    @(negedge ref_clk);
    chk(reg_rdata, exp, what);
  endtask

  // one-cycle overflow pulse from a neighbouring timer, random spacing
  task automatic tp(input bit which, input int d);
    @(posedge ref_clk);
    cmp_ovf <= which;
    sft_ovf <= !which;
    @(posedge ref_clk);
    cmp_ovf <= 1'b0;
    sft_ovf <= 1'b0;
    step(d);
    lf = lfsr(lf);
    repeat (lf[1:0]) @(posedge ref_clk);
  endtask

  task automatic end_sim;
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // sequence
  // ----------------------------------------------------------------
  initial begin
    forever #2 ref_clk = ~ref_clk;
  end

  initial begin
    repeat (20000) @(posedge ref_clk);
    fails++;
    end_sim();
  end

  initial begin
    repeat (8) @(posedge ref_clk);
    rst_n <= 1'b1;
    wr(4'hF, 16'h1234);
    // status bit3 comes out of reset showing the up direction
    foreach (lvt[j]) rc(4'(j), (j == 2) ? 16'h0008 : 16'h0000, "reset value");
    rc(4'hF, 16'h0000, "unmapped");
    $display("test reset done");
    foreach (cfg[i]) begin
      wr(ect_pkg::REG_CTRL, cfg[i] & ~ST);
      lf = lfsr(lf);
      n = cfg[i][6] ? {12'h000, lf[3:0]} : {12'hFFF, lf[3:0]};
      wr(ect_pkg::REG_COUNT, n);
      rc(ect_pkg::REG_COUNT, n, "stopped write");
      wr(ect_pkg::REG_CTRL, cfg[i]);
      repeat (12) tp(cfg[i][3], cfg[i][6] ? -1 : 1);
      wr(ect_pkg::REG_COUNT, n ^ 16'h0003);
      rc(ect_pkg::REG_COUNT, cnt, "running write");
      repeat (12) tp(cfg[i][3], cfg[i][6] ? -1 : 1);
      rc(ect_pkg::REG_COUNT, cnt, "count");
      if (cfg[i][9]) chk({15'h0000, out_o}, {15'h0000, tgl}, "pulse pin");
      wr(ect_pkg::REG_CTRL, cfg[i] & ~ST);
      tp(cfg[i][3], 1);
      rc(ect_pkg::REG_COUNT, cnt, "suspended");
      rc(ect_pkg::REG_RELOAD, n ^ 16'h0003, "reload");
    end
    $display("test single phase done");
    for (int e = 0; e < 4; e++) begin
      wr(ect_pkg::REG_CTRL, 16'h0000);
      wr(ect_pkg::REG_COUNT, 16'h0000);
      wr(ect_pkg::REG_CTRL, ST | (16'(e) << ect_pkg::CTL_EDGE_LO) | (e == 3 ? 16'h000C : 16'h0000));
      for (int k = 0; k < 4; k++) begin
        i_ect_pulse_src.set(!k[0], 1'b0, 6);
        step((e == 2 || e == int'(k[0])) ? 1 : 0);
      end
      rc(ect_pkg::REG_COUNT, cnt, "pin edges");
    end
    wr(ect_pkg::REG_COUNT, 16'h0008);
    wr(ect_pkg::REG_CTRL, ST | SFT | (16'h0001 << ect_pkg::CTL_DIR_EXT));
    repeat (3) tp(1'b0, -1);
    i_ect_pulse_src.set(1'b0, 1'b1, 4);
    repeat (5) tp(1'b0, 1);
    rc(ect_pkg::REG_COUNT, cnt, "pin direction");
    $display("test pins done");
    for (int m = 0; m < 2; m++) begin
      wr(ect_pkg::REG_CTRL, 16'h0000);
      i_ect_pulse_src.set(1'b0, 1'b0, 4);
      wr(ect_pkg::REG_COUNT, 16'h0001);
      wr(ect_pkg::REG_CTRL, ST | 16'h0002 | (16'(m) << ect_pkg::CTL_MUL4));
      foreach (qd[j]) begin
        lf = lfsr(lf);
        i_ect_pulse_src.quad(qd[j], 4 + 8 * lf[0]);
        repeat (m ? 4 : 1) step(qd[j]);
      end
      rc(ect_pkg::REG_COUNT, cnt, "two phase");
    end
    $display("test two phase done");
    chk({15'h0000, irq_request}, {15'h0000, irq}, "request");
    wr(ect_pkg::REG_PRIO, 16'h0005);
    foreach (lvt[j]) begin
      @(posedge ref_clk);
      gie <= (j != 2);
      lvl <= 3'(lvt[j]);
      repeat (3) @(posedge ref_clk);
      @(negedge ref_clk);
      chk({15'h0000, irq_accept}, {15'h0000, irq && j != 2 && lvt[j] < 5}, "accept");
    end
    wr(ect_pkg::REG_STATUS, 16'h0001);
    @(negedge ref_clk);
    chk({15'h0000, irq_request}, 16'h0000, "request clear");
    // source off the input pin, so both pins may be driven as ports
    wr(ect_pkg::REG_CTRL, 16'h7804);
    repeat (3) @(posedge ref_clk);
    @(negedge ref_clk);
    chk({12'h000, out_o, out_oe_n, in_o, in_oe_n}, 16'h000A, "port pins");
    rc(ect_pkg::REG_STATUS, 16'h0006, "pin levels");
    $display("test interrupt and ports done");
    end_sim();
  end
endmodule // event_counter_timer_test
`default_nettype wire
